// [hdl/pmic_enable_flag_regs.sv]
// Suspend flag, key and rail-enable registers of the power controller.
// Assumes the serial slave delivers one-cycle read/write strobes and that
// the sequencer and pin-mode bits are synchronous to clk.
//
// How it works
// - flag register at 0x07, read-only, resets zero
// - resume from suspend sets flags of enabled outputs
// - off power-up or disabled output clears flag
// - bits: out3..1, regulator, buck4..1
// - key register 0x10 resets zero, unlocks writes
// - key reads always return zero
// - converter enables at 0x11, bits 7:6 zero
// - bits 5:0 enable buck6..buck1
// - buck6 disable ignored while seal broken
// - buck5 disable ignored while broken; sequencer updates
// - sequencer writes buck1-5, switch1, regulator enables
// - switch enables at 0x12, bit 7 zero
// - bits 3:0 enable switch3..1 and regulator
// - bit 6 drives pin3 low; void in reset mode
// - bits 5:4 drive pins 2,1; void with select
// - seal status is status bit 7
// - reset mode makes pin3 warm-reset input
// - input select makes pin1 drive output two
`timescale 1ns/100ps
module pmic_enable_flag_regs (
  input  wire logic                      clk,          // 250 MHz clock
  input  wire logic                      reset,        // Power-on reset, sync
  input  wire pmic_regs_pkg::reg_req_s   req,          // Register access
  output logic [7:0]                     rdata,        // Read data, registered
  output logic                           rvalid,       // Read data valid pulse
  input  wire logic [7:0]                statusReg,    // Status register value
  input  wire pmic_regs_pkg::seq_upd_s   seqUpd,       // Sequencer enable update
  input  wire logic                      resumeEvt,    // Power-up strobe
  input  wire logic                      fromSuspend,  // Power-up was from suspend
  input  wire logic [7:0]                suspendOn,    // Outputs enabled in suspend
  input  wire logic                      warmResetPinMode, // Pin3 is reset input
  input  wire logic                      pin1InputSelAlt,  // Pin1 is input
  input  wire logic                      pin1In,       // Pin1 input level
  input  wire logic                      pin3In,       // Pin3 input level
  output logic [5:0]                     buckEnable,   // Buck 6..1 enables
  output logic [2:0]                     switchEnable, // Switch 3..1 enables
  output logic                           regulatorEnable, // Regulator enable
  output logic [2:0]                     pinOe,        // Pins 3..1 drive low
  output logic [2:0]                     pinOut,       // Pins 3..1 output value
  output logic                           warmResetBuck12 // Warm reset to buck 1,2
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] conv_q;
  logic [7:0] conv_d;
  logic [7:0] sw_q;
  logic [7:0] sw_d;
  logic [7:0] rdata_d;
  logic       rvalid_d;
  logic       unlocked;
  logic       keyWr;
  logic       protWr;
  logic       sealBroken;
  logic [7:0] wv;

  assign keyWr  = req.wrEn && (req.addr == pmic_regs_pkg::KEY_ADDR);
  assign protWr = req.wrEn && ((req.addr == pmic_regs_pkg::CONV_EN_ADDR) ||
                               (req.addr == pmic_regs_pkg::SW_EN_ADDR));
  assign sealBroken = statusReg[pmic_regs_pkg::SEAL_BIT];

  unlock_gate i_unlock_gate (
    .clk      (clk),
    .reset    (reset),
    .keyWr    (keyWr),
    .keyData  (req.wdata),
    .protWr   (protWr),
    .unlocked (unlocked)
  );

  // Flags change only on power-up; host writes never reach them
  always_comb begin
    flags_d = flags_q;
    if (resumeEvt) begin
      flags_d = fromSuspend ? suspendOn : pmic_regs_pkg::FLAG_RESET;
    end
  end

  // Sequencer wins over a host write in the same cycle; it owns power-up
  always_comb begin
    conv_d = conv_q;
    sw_d   = sw_q;
    wv     = req.wdata;
    if (req.wrEn && unlocked && req.addr == pmic_regs_pkg::CONV_EN_ADDR) begin
      if (sealBroken) begin
        wv[pmic_regs_pkg::BUCK6_BIT] = wv[pmic_regs_pkg::BUCK6_BIT] |
                                       conv_q[pmic_regs_pkg::BUCK6_BIT];
        wv[pmic_regs_pkg::BUCK5_BIT] = wv[pmic_regs_pkg::BUCK5_BIT] |
                                       conv_q[pmic_regs_pkg::BUCK5_BIT];
      end
      conv_d = wv & pmic_regs_pkg::CONV_EN_MASK;
    end
    if (req.wrEn && unlocked && req.addr == pmic_regs_pkg::SW_EN_ADDR) begin
      sw_d = req.wdata & pmic_regs_pkg::SW_EN_MASK;
    end
    if (seqUpd.update) begin
      conv_d = (conv_d & ~pmic_regs_pkg::CONV_SEQ_MASK) |
               (seqUpd.convVal & pmic_regs_pkg::CONV_SEQ_MASK);
      sw_d   = (sw_d & ~pmic_regs_pkg::SW_SEQ_MASK) |
               (seqUpd.swVal & pmic_regs_pkg::SW_SEQ_MASK);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = req.rdEn;
    if (req.rdEn) begin
      unique case (req.addr)
        pmic_regs_pkg::FLAG_ADDR:    rdata_d = flags_q;
        pmic_regs_pkg::KEY_ADDR:     rdata_d = pmic_regs_pkg::KEY_READ_VALUE;
        pmic_regs_pkg::CONV_EN_ADDR: rdata_d = conv_q;
        pmic_regs_pkg::SW_EN_ADDR:   rdata_d = sw_q;
        default:                     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= pmic_regs_pkg::FLAG_RESET;
      conv_q  <= pmic_regs_pkg::CONV_EN_RESET;
      sw_q    <= pmic_regs_pkg::SW_EN_RESET;
      rdata   <= 8'h00;
      rvalid  <= 1'b0;
    end else begin
      flags_q <= flags_d;
      conv_q  <= conv_d;
      sw_q    <= sw_d;
      rdata   <= rdata_d;
      rvalid  <= rvalid_d;
    end
  end

  assign buckEnable      = conv_q[5:0];
  assign switchEnable    = sw_q[3:1];
  assign regulatorEnable = sw_q[0];

  // Open-drain pins: a 0 bit pulls low, a 1 bit releases
  always_comb begin
    pinOut = 3'b000;
    pinOe[2] = !warmResetPinMode && !sw_q[pmic_regs_pkg::PIN3_LEVEL_BIT];
    if (pin1InputSelAlt) begin
      pinOe[0] = 1'b0;
      pinOe[1] = !pin1In;
    end else begin
      pinOe[0] = !sw_q[pmic_regs_pkg::PIN1_LEVEL_BIT];
      pinOe[1] = !sw_q[pmic_regs_pkg::PIN2_LEVEL_BIT];
    end
  end

  assign warmResetBuck12 = warmResetPinMode && !pin3In;

endmodule : pmic_enable_flag_regs

// [hdl/pmic_regs_pkg.sv]
// Package for the enable and suspend-flag register bank.
// Assumes a byte-wide register access port decoded by an upstream serial slave.
package pmic_regs_pkg;

  localparam logic [7:0] FLAG_ADDR      = 8'h07;
  localparam logic [7:0] KEY_ADDR       = 8'h10;
  localparam logic [7:0] CONV_EN_ADDR   = 8'h11;
  localparam logic [7:0] SW_EN_ADDR     = 8'h12;

  localparam logic [7:0] FLAG_RESET     = 8'h00;
  localparam logic [7:0] KEY_RESET      = 8'h00;
  localparam logic [7:0] KEY_READ_VALUE = 8'h00;
  localparam logic [7:0] CONV_EN_RESET  = 8'h00;
  localparam logic [7:0] SW_EN_RESET    = 8'h00;

  // Writable bits; reserved bits read zero
  localparam logic [7:0] CONV_EN_MASK   = 8'h3F;
  localparam logic [7:0] SW_EN_MASK     = 8'h7F;
  // Bits the sequencer may overwrite: buck1..5, switch1, regulator
  localparam logic [7:0] CONV_SEQ_MASK  = 8'h1F;
  localparam logic [7:0] SW_SEQ_MASK    = 8'h03;

  localparam int BUCK6_BIT      = 5;
  localparam int BUCK5_BIT      = 4;
  localparam int PIN3_LEVEL_BIT = 6;
  localparam int PIN2_LEVEL_BIT = 5;
  localparam int PIN1_LEVEL_BIT = 4;
  localparam int SEAL_BIT       = 7;

  // Arbitrary unlock value; the real key scheme is outside this block
  localparam logic [7:0] UNLOCK_VALUE   = 8'hA5;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       update;   // One-cycle strobe
    logic [7:0] convVal;  // Only CONV_SEQ_MASK bits used
    logic [7:0] swVal;    // Only SW_SEQ_MASK bits used
  } seq_upd_s;

endpackage : pmic_regs_pkg

// [hdl/unlock_gate.sv]
// Unlock qualifier from the key register.
// Assumes writes to the key address arrive as one-cycle strobes.
`timescale 1ns/100ps
module unlock_gate (
  input  wire logic       clk,      // 250 MHz clock
  input  wire logic       reset,    // Sync, active high
  input  wire logic       keyWr,    // Key register write strobe
  input  wire logic [7:0] keyData,  // Key value written
  input  wire logic       protWr,   // Protected register write strobe
  output logic            unlocked  // Next protected write allowed
);
  logic armed_q;
  logic armed_d;

  // One protected write per key write; a protected write or a wrong key value re-locks
  always_comb begin
    armed_d = armed_q;
    if (keyWr) begin
      armed_d = (keyData == pmic_regs_pkg::UNLOCK_VALUE);
    end else if (protWr) begin
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  assign unlocked = armed_q;

endmodule : unlock_gate

// [sim/pmic_enable_flag_regs_checker.sv]
// Assertions on the enable and flag bank ports.
// Bound into every bank instance; single clock domain.
`timescale 1ns/100ps
module pmic_enable_flag_regs_checker (
  input wire logic                    clk, // Clock
  input wire logic                    reset, // Sync reset
  input wire pmic_regs_pkg::reg_req_s req, // Access
  input wire logic [7:0]              rdata, // Read data
  input wire logic                    rvalid, // Read pulse
  input wire logic [7:0]              statusReg, // Bit 7 seal
  input wire pmic_regs_pkg::seq_upd_s seqUpd, // Sequencer
  input wire logic [5:0]              buckEnable, // Bucks
  input wire logic                    warmResetPinMode, // Pin3 mode
  input wire logic                    pin3In, // Pin3 level
  input wire logic [2:0]              pinOe, // Pull-low
  input wire logic                    warmResetBuck12 // Warm reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence rdAt(logic [7:0] a);
    req.rdEn && req.addr == a;
  endsequence
  keyRead_a: assert property (rdAt(8'h10) |=> rvalid && rdata == 8'h00)
    else $error("key read not zero");
  convRsv_a: assert property (rdAt(8'h11) |=> rvalid && rdata[7:6] == 2'h0)
    else $error("converter reserved bits set");
  swRsv_a: assert property (rdAt(8'h12) |=> rvalid && !rdata[7])
    else $error("switch reserved bit set");
  buck6Hold_a: assert property (statusReg[7] && buckEnable[5] |=> buckEnable[5])
    else $error("buck6 cleared with seal broken");
  buck5Hold_a: assert property (
    statusReg[7] && buckEnable[4] && !seqUpd.update |=> buckEnable[4])
    else $error("buck5 cleared with seal broken");
  seqApply_a: assert property (
    seqUpd.update |=> buckEnable[4:0] == $past(seqUpd.convVal[4:0]))
    else $error("sequencer update lost");
  warmRst_a: assert property (warmResetBuck12 == (warmResetPinMode && !pin3In))
    else $error("warm reset mismatch");
  pin3Mode_a: assert property (warmResetPinMode |-> !pinOe[2])
    else $error("pin3 driven in reset mode");
endmodule : pmic_enable_flag_regs_checker
bind pmic_enable_flag_regs pmic_enable_flag_regs_checker i_checker (.*);

// [sim/reg_host_model.sv]
// Host side of the register port: byte writes and reads.
// Assumes one request at a time, changed only at falling edges.
`timescale 1ns/100ps
module reg_host_model (
  input  wire logic                clk, // Clock
  output pmic_regs_pkg::reg_req_s  req, // Request
  input  wire logic [7:0]          rdata, // Read data
  input  wire logic                rvalid // Read pulse
);
  initial req = '0;
  // Released fields show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req <= '{1'h1, 1'h0, a, d};
    @(negedge clk) req <= '{1'h0, 1'h0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk) req <= '{1'h0, 1'h1, a, ~a};
    @(negedge clk) req <= '{1'h0, 1'h0, ~a, a};
    d = rdata;
    v = rvalid;
  endtask : rd
endmodule : reg_host_model

// [sim/test_pmic_enable_flag_regs.sv]
// Self-checking bench for the enable and flag register bank.
// Host model drives the register port; side inputs change at falling edges.
`timescale 1ns/100ps
module test_pmic_enable_flag_regs;
  logic                    clk = 1'h0, reset = 1'h1, resumeEvt = 1'h0, fromSuspend = 1'h0;
  logic                    warmResetPinMode = 1'h0, pin1InputSelAlt = 1'h0, pin1In = 1'h1;
  logic                    pin3In = 1'h1, rvalid, regulatorEnable, warmResetBuck12, v;
  logic [7:0]              rdata, d, statusReg = 8'h00, suspendOn = 8'h00;
  logic [5:0]              buckEnable;
  logic [2:0]              switchEnable, pinOe, pinOut;
  pmic_regs_pkg::reg_req_s req;
  pmic_regs_pkg::seq_upd_s seqUpd = '0;
  int                      fails = 0, checkCount = 0;
  pmic_enable_flag_regs i_pmic_enable_flag_regs (.*);
  reg_host_model        i_reg_host_model (.*);
  initial forever #2 clk = ~clk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_reg_host_model.rd(a, d, v);
    cmp(v === 1'h1 ? d : ~exp, exp);
  endtask : rdc
  task automatic unlock(input logic [7:0] a, input logic [7:0] dat);
    i_reg_host_model.wr(8'h10, 8'hA5);
    i_reg_host_model.wr(a, dat);
  endtask : unlock
  task automatic powerUp(input logic [7:0] s, input logic f);
    suspendOn = s;
    fromSuspend = f;
    resumeEvt = 1'h1;
    @(negedge clk) resumeEvt = 1'h0;
  endtask : powerUp
  task automatic t_access;
    rdc(8'h07, 8'h00);
    rdc(8'h12, 8'h00);
    i_reg_host_model.wr(8'h10, 8'hA5);
    i_reg_host_model.wr(8'h10, 8'h5A);
    i_reg_host_model.wr(8'h11, 8'h3F);
    rdc(8'h11, 8'h00);
    unlock(8'h11, 8'hFF);
    rdc(8'h11, 8'h3F);
    i_reg_host_model.wr(8'h11, 8'h00);
    cmp({2'h0, buckEnable}, 8'h3F);
    i_reg_host_model.wr(8'h07, 8'hFF);
    rdc(8'h07, 8'h00);
    rdc(8'h10, 8'h00);
    $display("access test done");
  endtask : t_access
  task automatic t_seal;
    statusReg = 8'h80;
    unlock(8'h11, 8'h00);
    cmp({2'h0, buckEnable}, 8'h30);
    statusReg = 8'h00;
    unlock(8'h11, 8'h00);
    cmp({2'h0, buckEnable}, 8'h00);
    $display("seal test done");
  endtask : t_seal
  task automatic t_pins;
    unlock(8'h12, 8'hFF);
    rdc(8'h12, 8'h7F);
    cmp({1'h0, pinOe, switchEnable, regulatorEnable}, 8'h0F);
    unlock(8'h12, 8'h0E);
    cmp({1'h0, pinOe, switchEnable, regulatorEnable}, 8'h7E);
    pin1InputSelAlt = 1'h1;
    pin1In = 1'h0;
    warmResetPinMode = 1'h1;
    pin3In = 1'h0;
    @(negedge clk);
    cmp({4'h0, pinOe, warmResetBuck12}, 8'h05);
    cmp({5'h00, pinOut}, 8'h00);
    $display("pin test done");
  endtask : t_pins
  task automatic t_seq;
    @(negedge clk) seqUpd = '{1'h1, 8'h15, 8'h01};
    @(negedge clk) seqUpd = '{1'h0, 8'hEA, 8'hFE};
    cmp({buckEnable, switchEnable[0], regulatorEnable}, 8'h55);
    powerUp(8'hA5, 1'h1);
    rdc(8'h07, 8'hA5);
    powerUp(8'h5A, 1'h1);
    rdc(8'h07, 8'h5A);
    powerUp(8'hFF, 1'h0);
    rdc(8'h07, 8'h00);
    $display("sequencer test done");
  endtask : t_seq
  task automatic close_out;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'h0;
    t_access;
    t_seal;
    t_pins;
    t_seq;
    close_out;
  end
  // Tests need under a hundred cycles; this leaves wide margin
  initial begin
    #20000;
    fails++;
    close_out;
  end
endmodule : test_pmic_enable_flag_regs
